// file: ocr_pkg.sv
// constants for the output routing control block
package ocr_pkg;

  // register index width and offsets
  localparam int unsigned ADDR_W = 4;
  localparam logic [3:0] OFS_HIGH_NUM = 4'h6;
  localparam logic [3:0] OFS_ROUTING = 4'h7;
  localparam logic [3:0] OFS_NUM_LOW = 4'h8;
  localparam logic [3:0] OFS_SPREAD = 4'h9;

  // values held before the fuse words arrive
  localparam logic [15:0] RST_HIGH_NUM = 16'h0AA0;
  localparam logic [15:0] RST_ROUTING = 16'h6503;
  localparam logic [15:0] RST_NUM_LOW = 16'hC28F;
  localparam logic [15:0] RST_SPREAD = 16'h3066;

  // routing register fields
  localparam int unsigned BIT_RSVD_ZERO = 15;
  localparam int unsigned BIT_ROLE_HI = 14;
  localparam int unsigned BIT_ROLE_LO = 13;
  localparam int unsigned BIT_AUXDIV_HI = 12;
  localparam int unsigned BIT_AUXDIV_LO = 11;
  localparam int unsigned BIT_RSVD_ONE = 10;
  localparam int unsigned BIT_AUX_SRC = 9;
  localparam int unsigned BIT_EN1 = 8;
  localparam int unsigned BIT_SRC1 = 7;
  localparam int unsigned BIT_SLEW_HI = 6;
  localparam int unsigned BIT_SLEW_LO = 5;
  localparam int unsigned BIT_FMT_HI = 4;
  localparam int unsigned BIT_FMT_LO = 2;
  localparam int unsigned BIT_EN0 = 1;
  localparam int unsigned BIT_OE_POL = 0;

  // upper numerator byte inside the earlier register
  localparam int unsigned BIT_NUMHI_HI = 12;
  localparam int unsigned BIT_NUMHI_LO = 5;

  // aux pin roles
  typedef enum logic [1:0] {
    ROLE_GROUNDED = 2'h0,
    ROLE_TRISTATE = 2'h1,
    ROLE_CLOCK = 2'h2,
    ROLE_READY = 2'h3
  } ocr_role_t;

  // aux divisor codes
  localparam logic [1:0] AUXDIV_OFF = 2'h0;

  // highest standard code that is differential
  localparam logic [2:0] FMT_DIFF_MAX = 3'h3;

  // synchronised pin inputs
  localparam int unsigned N_SYNC = 6;
  localparam int unsigned SY_FRAC0 = 0;
  localparam int unsigned SY_FRAC1 = 1;
  localparam int unsigned SY_CH0 = 2;
  localparam int unsigned SY_CH1 = 3;
  localparam int unsigned SY_COMB = 4;
  localparam int unsigned SY_OE = 5;

endpackage : ocr_pkg

// file: ocr_aux_div.sv
// divider that makes the aux pin clock from a synchronised source level
`timescale 1ns/10ps
`default_nettype none
module ocr_aux_div (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // control
  input wire logic run,
  input wire logic [1:0] div_code,
  // source and result
  input wire logic src_level,
  output logic aux_clk
);

  logic [2:0] cnt_ff;
  logic [2:0] nxt_cnt;
  logic src_prev_ff;
  logic nxt_src_prev;
  logic aux_clk_ff;
  logic nxt_aux_clk;

  always_comb begin
    nxt_src_prev = src_level;
    nxt_cnt = cnt_ff;
    nxt_aux_clk = 1'b0;
    if (!run || div_code == ocr_pkg::AUXDIV_OFF) begin
      nxt_cnt = 3'h0;
    end else begin
      // count source rising edges; bit n toggles every 2^n edges
      if (src_level && !src_prev_ff) begin
        nxt_cnt = cnt_ff + 3'h1;
      end
      nxt_aux_clk = nxt_cnt[div_code - 2'h1];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      cnt_ff <= 3'h0;
      src_prev_ff <= 1'b0;
      aux_clk_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      src_prev_ff <= nxt_src_prev;
      aux_clk_ff <= nxt_aux_clk;
    end
  end

  assign aux_clk = aux_clk_ff;

endmodule : ocr_aux_div
`default_nettype wire

// file: ocr_routing.sv
// output routing control registers and clock output gating
`timescale 1ns/10ps
`default_nettype none
module ocr_routing (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  // fuse storage
  input wire logic fuse_load,
  input wire logic [15:0] fuse_high_num,
  input wire logic [15:0] fuse_routing,
  input wire logic [15:0] fuse_num_low,
  input wire logic [15:0] fuse_spread,
  // clock sources and pins, asynchronous
  input wire logic frac0_clk,
  input wire logic frac1_clk,
  input wire logic ch0_div_clk,
  input wire logic ch1_div_clk,
  input wire logic combiner_clk,
  input wire logic oe_pin,
  // same-domain status and flags
  input wire logic clk_ready,
  input wire logic channel_zero_combiner_flag,
  input wire logic channel_one_combiner_flag,
  // outputs
  output logic first_clock_output,
  output logic second_clock_output,
  output logic aux_pin_out,
  output logic aux_pin_oe,
  output logic [2:0] second_output_standard,
  output logic [1:0] second_output_edge_rate,
  output logic [23:0] second_divider_numerator
);

  // input synchronisers: a change counts once stages two and three agree
  logic [ocr_pkg::N_SYNC-1:0] async_in;
  logic [ocr_pkg::N_SYNC-1:0] sy1_ff;
  logic [ocr_pkg::N_SYNC-1:0] sy2_ff;
  logic [ocr_pkg::N_SYNC-1:0] sy3_ff;
  logic [ocr_pkg::N_SYNC-1:0] filt_ff;
  logic [ocr_pkg::N_SYNC-1:0] nxt_filt;

  assign async_in = {oe_pin, combiner_clk, ch1_div_clk, ch0_div_clk, frac1_clk, frac0_clk};

  genvar gi;
  generate
    for (gi = 0; gi < ocr_pkg::N_SYNC; gi++) begin : g_sync
      always_comb begin
        nxt_filt[gi] = (sy2_ff[gi] == sy3_ff[gi]) ? sy3_ff[gi] : filt_ff[gi];
      end
      always_ff @(posedge core_clk) begin
        if (!rstn) begin
          sy1_ff[gi] <= 1'b0;
          sy2_ff[gi] <= 1'b0;
          sy3_ff[gi] <= 1'b0;
          filt_ff[gi] <= 1'b0;
        end else begin
          sy1_ff[gi] <= async_in[gi];
          sy2_ff[gi] <= sy1_ff[gi];
          sy3_ff[gi] <= sy2_ff[gi];
          filt_ff[gi] <= nxt_filt[gi];
        end
      end
    end
  endgenerate

  // register file
  logic [15:0] high_num_ff, routing_ff, num_low_ff, spread_ff, rdata_ff;
  logic [15:0] nxt_high_num, nxt_routing, nxt_num_low, nxt_spread, nxt_rdata;
  logic load_pend_ff;
  logic nxt_load_pend;

  always_comb begin
    nxt_high_num = high_num_ff;
    nxt_routing = routing_ff;
    nxt_num_low = num_low_ff;
    nxt_spread = spread_ff;
    nxt_rdata = rdata_ff;
    nxt_load_pend = 1'b0;
    // fuse words win over a software write in the same cycle
    if (load_pend_ff || fuse_load) begin
      nxt_high_num = fuse_high_num;
      nxt_routing = fuse_routing;
      nxt_num_low = fuse_num_low;
      nxt_spread = fuse_spread;
    end else if (reg_wr) begin
      case (reg_addr)
        ocr_pkg::OFS_HIGH_NUM: nxt_high_num = reg_wdata;
        ocr_pkg::OFS_ROUTING: nxt_routing = reg_wdata;
        ocr_pkg::OFS_NUM_LOW: nxt_num_low = reg_wdata;
        ocr_pkg::OFS_SPREAD: nxt_spread = reg_wdata;
        default: nxt_spread = spread_ff;
      endcase
    end
    // reserved top bit is held low whatever is written
    nxt_routing[ocr_pkg::BIT_RSVD_ZERO] = 1'b0;
    if (reg_rd) begin
      case (reg_addr)
        ocr_pkg::OFS_HIGH_NUM: nxt_rdata = high_num_ff;
        ocr_pkg::OFS_ROUTING: nxt_rdata = routing_ff;
        ocr_pkg::OFS_NUM_LOW: nxt_rdata = num_low_ff;
        ocr_pkg::OFS_SPREAD: nxt_rdata = spread_ff;
        default: nxt_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      high_num_ff <= ocr_pkg::RST_HIGH_NUM;
      routing_ff <= ocr_pkg::RST_ROUTING;
      num_low_ff <= ocr_pkg::RST_NUM_LOW;
      spread_ff <= ocr_pkg::RST_SPREAD;
      rdata_ff <= 16'h0000;
      load_pend_ff <= 1'b1;
    end else begin
      high_num_ff <= nxt_high_num;
      routing_ff <= nxt_routing;
      num_low_ff <= nxt_num_low;
      spread_ff <= nxt_spread;
      rdata_ff <= nxt_rdata;
      load_pend_ff <= nxt_load_pend;
    end
  end

  // field views
  logic [1:0] role, aux_div, slew1;
  logic [2:0] fmt1;
  logic en0, en1, pol, pin_active, comb_active, src1, src0, aux_div_clk;

  assign role = routing_ff[ocr_pkg::BIT_ROLE_HI:ocr_pkg::BIT_ROLE_LO];
  assign aux_div = routing_ff[ocr_pkg::BIT_AUXDIV_HI:ocr_pkg::BIT_AUXDIV_LO];
  assign fmt1 = routing_ff[ocr_pkg::BIT_FMT_HI:ocr_pkg::BIT_FMT_LO];
  assign slew1 = routing_ff[ocr_pkg::BIT_SLEW_HI:ocr_pkg::BIT_SLEW_LO];
  assign en0 = routing_ff[ocr_pkg::BIT_EN0];
  assign en1 = routing_ff[ocr_pkg::BIT_EN1];
  assign pol = routing_ff[ocr_pkg::BIT_OE_POL];
  // polarity flips the pin only, enable bits keep their sense
  assign pin_active = pol ? !filt_ff[ocr_pkg::SY_OE] : filt_ff[ocr_pkg::SY_OE];
  assign comb_active = channel_zero_combiner_flag || channel_one_combiner_flag;

  always_comb begin
    src0 = channel_zero_combiner_flag ? filt_ff[ocr_pkg::SY_COMB]
                                      : filt_ff[ocr_pkg::SY_CH0];
    if (comb_active) begin
      src1 = filt_ff[ocr_pkg::SY_COMB];
    end else if (routing_ff[ocr_pkg::BIT_SRC1]) begin
      src1 = filt_ff[ocr_pkg::SY_CH1];
    end else begin
      src1 = filt_ff[ocr_pkg::SY_CH0];
    end
  end

  ocr_aux_div u_aux_div (
    .core_clk(core_clk),
    .rstn(rstn),
    .run(role == ocr_pkg::ROLE_CLOCK),
    .div_code(aux_div),
    .src_level(routing_ff[ocr_pkg::BIT_AUX_SRC] ? filt_ff[ocr_pkg::SY_FRAC1]
                                                : filt_ff[ocr_pkg::SY_FRAC0]),
    .aux_clk(aux_div_clk)
  );

  // output stage, every output straight from a flop
  logic first_out_ff, second_out_ff, aux_out_ff, aux_oe_ff;
  logic nxt_first_out, nxt_second_out, nxt_aux_out, nxt_aux_oe;
  logic [2:0] fmt_ff, nxt_fmt;
  logic [1:0] slew_ff, nxt_slew;
  logic [23:0] num_ff, nxt_num;

  always_comb begin
    // disabled outputs park low
    nxt_first_out = en0 && pin_active && src0;
    nxt_second_out = en1 && pin_active && src1;
    nxt_fmt = fmt1;
    // single-ended standards have no edge-rate control
    nxt_slew = (fmt1 <= ocr_pkg::FMT_DIFF_MAX) ? slew1 : 2'h0;
    nxt_num = {high_num_ff[ocr_pkg::BIT_NUMHI_HI:ocr_pkg::BIT_NUMHI_LO], num_low_ff};
    case (role)
      ocr_pkg::ROLE_GROUNDED: begin
        nxt_aux_out = 1'b0;
        nxt_aux_oe = 1'b1;
      end
      ocr_pkg::ROLE_TRISTATE: begin
        nxt_aux_out = 1'b0;
        nxt_aux_oe = 1'b0;
      end
      ocr_pkg::ROLE_CLOCK: begin
        nxt_aux_out = aux_div_clk;
        nxt_aux_oe = 1'b1;
      end
      ocr_pkg::ROLE_READY: begin
        nxt_aux_out = clk_ready;
        nxt_aux_oe = 1'b1;
      end
      default: begin
        nxt_aux_out = 1'b0;
        nxt_aux_oe = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      first_out_ff <= 1'b0;
      second_out_ff <= 1'b0;
      aux_out_ff <= 1'b0;
      aux_oe_ff <= 1'b0;
      fmt_ff <= 3'h0;
      slew_ff <= 2'h0;
      num_ff <= 24'h000000;
    end else begin
      first_out_ff <= nxt_first_out;
      second_out_ff <= nxt_second_out;
      aux_out_ff <= nxt_aux_out;
      aux_oe_ff <= nxt_aux_oe;
      fmt_ff <= nxt_fmt;
      slew_ff <= nxt_slew;
      num_ff <= nxt_num;
    end
  end

  assign reg_rdata = rdata_ff;
  assign first_clock_output = first_out_ff;
  assign second_clock_output = second_out_ff;
  assign aux_pin_out = aux_out_ff;
  assign aux_pin_oe = aux_oe_ff;
  assign second_output_standard = fmt_ff;
  assign second_output_edge_rate = slew_ff;
  assign second_divider_numerator = num_ff;

  // checks
  property p_rsvd_zero;
    @(posedge core_clk) disable iff (!rstn)
    $past(rstn) |-> !routing_ff[ocr_pkg::BIT_RSVD_ZERO];
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit 15 set");

  property p_grounded;
    @(posedge core_clk) disable iff (!rstn)
    role == 2'h0 |=> aux_pin_oe && !aux_pin_out;
  endproperty
  a_grounded: assert property (p_grounded) else $error("aux pin not grounded");

  property p_tristate;
    @(posedge core_clk) disable iff (!rstn)
    role == 2'h1 |=> !aux_pin_oe;
  endproperty
  a_tristate: assert property (p_tristate) else $error("aux pin driven in tri-state");

  property p_ready;
    @(posedge core_clk) disable iff (!rstn)
    role == 2'h3 |=> aux_pin_oe && aux_pin_out == $past(clk_ready);
  endproperty
  a_ready: assert property (p_ready) else $error("ready flag not on aux pin");

  property p_aux_off;
    @(posedge core_clk) disable iff (!rstn)
    (role == 2'h2 && aux_div == 2'h0) [*3] |=> !aux_pin_out;
  endproperty
  a_aux_off: assert property (p_aux_off) else $error("aux clock runs while off");

  property p_comb_wins;
    @(posedge core_clk) disable iff (!rstn)
    comb_active |=> second_clock_output == $past(en1 && pin_active && filt_ff[ocr_pkg::SY_COMB]);
  endproperty
  a_comb_wins: assert property (p_comb_wins) else $error("source bit used with combiner");

  property p_first_clock_output_gate;
    @(posedge core_clk) disable iff (!rstn)
    (!en0 || !pin_active) |=> !first_clock_output;
  endproperty
  a_first_clock_output_gate: assert property (p_first_clock_output_gate) else $error("first output not gated");

  property p_second_clock_output_pol;
    @(posedge core_clk) disable iff (!rstn)
    (pol && !filt_ff[ocr_pkg::SY_OE] && en1 && !comb_active && !routing_ff[ocr_pkg::BIT_SRC1]
      && filt_ff[ocr_pkg::SY_CH0]) |=> second_clock_output;
  endproperty
  a_second_clock_output_pol: assert property (p_second_clock_output_pol) else $error("low pin does not enable");

  property p_slew_se;
    @(posedge core_clk) disable iff (!rstn)
    fmt1 > 3'h3 |=> second_output_edge_rate == 2'h0;
  endproperty
  a_slew_se: assert property (p_slew_se) else $error("edge rate on single-ended");

  property p_num;
    @(posedge core_clk) disable iff (!rstn)
    1'b1 |=> second_divider_numerator == {$past(high_num_ff[12:5]), $past(num_low_ff)};
  endproperty
  a_num: assert property (p_num) else $error("numerator assembly wrong");

  property p_fuse;
    @(posedge core_clk) disable iff (!rstn)
    fuse_load |=> num_low_ff == $past(fuse_num_low) && high_num_ff == $past(fuse_high_num);
  endproperty
  a_fuse: assert property (p_fuse) else $error("fuse word not loaded");

  c_aux_clock: cover property (@(posedge core_clk) disable iff (!rstn)
    role == 2'h2 && aux_div == 2'h3 && aux_pin_out);
  c_comb: cover property (@(posedge core_clk) disable iff (!rstn)
    comb_active && second_clock_output);
  c_pol_low: cover property (@(posedge core_clk) disable iff (!rstn)
    !pol && pin_active && first_clock_output);

endmodule : ocr_routing
`default_nettype wire

// file: output_routing_control_regs_tb.sv
// self-checking testbench for the output routing control registers
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin \
  checks_done++; \
  if ((got) !== (exp)) begin \
    bad_count++; \
    $display("MISMATCH t=%0t got %0h exp %0h", $time, got, exp); \
  end \
end
module output_routing_control_regs_tb;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic fuse_load = 1'b0;
  logic [15:0] fuse_high_num, fuse_routing, fuse_num_low, fuse_spread;
  logic frac0_clk = 1'b0, frac1_clk = 1'b0, ch0_div_clk = 1'b0, ch1_div_clk = 1'b0;
  logic combiner_clk = 1'b0, oe_pin = 1'b0, clk_ready = 1'b0, flag0 = 1'b0, flag1 = 1'b0;
  logic [15:0] reg_rdata;
  logic first_out, second_out, aux_out, aux_oe, aux_q, cnt_en;
  logic [2:0] std_out;
  logic [1:0] rate_out;
  logic [23:0] num_out;
  logic [31:0] rnd;
  int mreg [6:9];
  int bad_count = 0, checks_done = 0, cyc = 0, aux_cnt = 0, ex;

  ocr_routing dut (
    .core_clk(core_clk), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .fuse_load(fuse_load), .fuse_high_num(fuse_high_num), .fuse_routing(fuse_routing),
    .fuse_num_low(fuse_num_low), .fuse_spread(fuse_spread),
    .frac0_clk(frac0_clk), .frac1_clk(frac1_clk), .ch0_div_clk(ch0_div_clk),
    .ch1_div_clk(ch1_div_clk), .combiner_clk(combiner_clk), .oe_pin(oe_pin),
    .clk_ready(clk_ready), .channel_zero_combiner_flag(flag0),
    .channel_one_combiner_flag(flag1), .first_clock_output(first_out),
    .second_clock_output(second_out), .aux_pin_out(aux_out), .aux_pin_oe(aux_oe),
    .second_output_standard(std_out), .second_output_edge_rate(rate_out),
    .second_divider_numerator(num_out)
  );

  always #5 core_clk = ~core_clk;

  // rising edges of the aux pin, counted only inside a divider window
  always @(posedge core_clk) begin
    aux_q <= aux_out;
    if (cnt_en && aux_out && !aux_q) aux_cnt++;
    cyc++;
    if (cyc == 12000) begin
      bad_count++;
      end_sim();
    end
  end

  task end_sim;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_sim

  // fuse words replace the model; bit 15 of routing is never kept
  task load_model;
    mreg[6] = fuse_high_num;
    mreg[7] = fuse_routing & 16'h7FFF;
    mreg[8] = fuse_num_low;
    mreg[9] = fuse_spread;
  endtask : load_model

  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    #1;
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge core_clk);
    #1;
    reg_wr = 1'b0;
    if (a >= 4'h6 && a <= 4'h9) mreg[a] = (a == 4'h7) ? (d & 16'h7FFF) : d;
  endtask : wr

  task rd(input logic [3:0] a);
    logic [15:0] e;
    e = (a >= 4'h6 && a <= 4'h9) ? mreg[a][15:0] : 16'h0000;
    @(posedge core_clk);
    #1;
    reg_rd = 1'b1;
    reg_addr = a;
    @(posedge core_clk);
    #1;
    reg_rd = 1'b0;
    `CHK(reg_rdata, e)
  endtask : rd

  task rd_all;
    for (int a = 5; a <= 10; a++) rd(a[3:0]);
  endtask : rd_all

  // static sources: outputs settle through the pin synchronisers
  task chk_outs;
    logic [15:0] r;
    logic act, s0, s1;
    logic [1:0] er;
    repeat (8) @(posedge core_clk);
    #1;
    r = mreg[7][15:0];
    act = r[0] ? !oe_pin : oe_pin;
    s0 = flag0 ? combiner_clk : ch0_div_clk;
    s1 = (flag0 || flag1) ? combiner_clk : (r[7] ? ch1_div_clk : ch0_div_clk);
    er = (r[4:2] <= 3'h3) ? r[6:5] : 2'h0;
    `CHK(first_out, r[1] & act & s0)
    `CHK(second_out, r[8] & act & s1)
    `CHK(std_out, r[4:2])
    `CHK(rate_out, er)
    `CHK(num_out, {mreg[6][12:5], mreg[8][15:0]})
    if (r[14:13] != 2'h1 && r[14:13] != 2'h2) begin
      `CHK(aux_out, (r[14:13] == 2'h3) & clk_ready)
    end
    `CHK(aux_oe, r[14:13] != 2'h1)
  endtask : chk_outs

  initial begin
    void'($urandom(4));
    rnd = $urandom;
    fuse_high_num = rnd[15:0];
    fuse_routing = rnd[31:16] | 16'h8400;
    rnd = $urandom;
    fuse_num_low = rnd[15:0];
    fuse_spread = rnd[31:16];
    cnt_en = 1'b0;
    repeat (12) @(posedge core_clk);
    #1;
    rstn = 1'b1;
    load_model();
    rd_all();
    $display("test fuse_start done");

    // random register contents against every output except the aux pin level in tri-state and clock roles, including unmapped places
    for (int i = 0; i < 40; i++) begin
      rnd = $urandom;
      rnd[15] = 1'b0;
      rnd[10] = 1'b1;
      if (i < 8) rnd[4:2] = i[2:0];
      wr(4'h7, rnd[15:0]);
      rnd = $urandom;
      wr(4'h6, rnd[15:0]);
      wr(4'h8, rnd[31:16]);
      rnd = $urandom;
      wr(4'h5, rnd[15:0]);
      {frac0_clk, ch0_div_clk, ch1_div_clk, combiner_clk} = rnd[19:16];
      {oe_pin, clk_ready, flag0, flag1} = rnd[23:20];
      wr(4'h9, rnd[31:16]);
      rd(4'h7);
      rd(4'h8);
      chk_outs();
    end
    rd_all();
    $display("test random_regs done");

    // fuse pulse wins over a write in the same cycle
    rnd = $urandom;
    fuse_high_num = rnd[15:0];
    fuse_num_low = rnd[31:16];
    @(posedge core_clk);
    #1;
    fuse_load = 1'b1;
    reg_wr = 1'b1;
    reg_addr = 4'h8;
    reg_wdata = ~rnd[31:16];
    @(posedge core_clk);
    #1;
    fuse_load = 1'b0;
    reg_wr = 1'b0;
    load_model();
    rd_all();
    chk_outs();
    $display("test fuse_pulse done");

    // aux divider: the two sources run at different rates, so the count shows the pick
    {frac0_clk, oe_pin, flag0, flag1} = 4'h0;
    for (int m = 0; m < 8; m++) begin
      wr(4'h7, {3'h2, m[1:0], 1'b1, m[2], 9'h000});
      aux_cnt = 0;
      cnt_en = 1'b1;
      for (int k = 0; k < 32; k++) begin
        repeat (4) @(posedge core_clk);
        #1;
        frac1_clk = 1'b1;
        frac0_clk = k[0];
        repeat (4) @(posedge core_clk);
        #1;
        frac1_clk = 1'b0;
      end
      repeat (8) @(posedge core_clk);
      #1;
      cnt_en = 1'b0;
      ex = (m[1:0] == 2'h0) ? 0 : ((m[2] ? 32 : 16) >> m[1:0]);
      `CHK((aux_cnt + 1 >= ex) && (aux_cnt <= ex + 1), 1'b1)
      `CHK(m[1:0] != 2'h0 || aux_cnt == 0, 1'b1)
      `CHK(aux_oe, 1'b1)
    end
    $display("test aux_divider done");
    end_sim();
  end
endmodule : output_routing_control_regs_tb
`default_nettype wire
